//--- inc/ch0_cal_map.vh
`ifndef CH0_CAL_MAP_VH
`define CH0_CAL_MAP_VH

// Register indices; byte address is four times the index
`define IDX_CH0_CHANNEL_CONFIG 5'h09
`define IDX_CH0_OFFSET_CAL_HIGH 5'h0A
`define IDX_CH0_OFFSET_CAL_LOW 5'h0B
`define IDX_CH0_GAIN_CAL_HIGH 5'h0C
`define IDX_CH0_GAIN_CAL_LOW 5'h0D
`define IDX_CORR_STATUS 5'h14

// Reset values
`define RST_CH0_CHANNEL_CONFIG 16'h0000
`define RST_CH0_OFFSET_CAL_HIGH 16'h0000
`define RST_CH0_OFFSET_CAL_LOW 8'h00
`define RST_CH0_GAIN_CAL_HIGH 16'h8000
`define RST_CH0_GAIN_CAL_LOW 8'h00
`define RST_CH0_INPUT_SELECT 2'h0
`define RST_CH0_DC_BYPASS 1'h0
`define RST_CH0_SEL_ONEHOT 4'h1

// Field positions of ch0_channel_config
`define CFG_BYPASS_BIT 2
`define CFG_SEL_HI 1
`define CFG_SEL_LO 0

// Input select codes
`define SEL_OWN_PAIR 2'h0
`define SEL_SHORTED 2'h1
`define SEL_TEST_POS 2'h2
`define SEL_TEST_NEG 2'h3

// Gain fraction bits: unity is 2^23
`define GAIN_FRAC_BITS 23

`endif

//--- hw/cal_correct.v
`include "ch0_cal_map.vh"

// Two-stage correction: subtract offset, then scale by gain
module cal_correct #(
    parameter W = 24
) (
    input wire mclk,
    input wire rst,
    input wire in_valid,
    input wire [W-1:0] in_data,
    input wire [W-1:0] offset_word,
    input wire [W-1:0] gain_word,
    output reg out_valid,
    output reg [W-1:0] out_data
);
    // --------------------------------------------------------
    // Stage 1: offset removal, one guard bit
    // --------------------------------------------------------
    reg [W:0] diff_r;
    reg diff_v_r;
    wire signed [2*W+1:0] prod;
    wire signed [2*W+1:0] scaled;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            diff_r <= {(W+1){1'b0}};
            diff_v_r <= 1'b0;
        end else begin
            diff_v_r <= in_valid;
            if (in_valid) begin
                diff_r <= {in_data[W-1], in_data} - {offset_word[W-1], offset_word};
            end
        end
    end

    // --------------------------------------------------------
    // Stage 2: gain scaling with saturation
    // --------------------------------------------------------
    // Saturate rather than wrap; a wrapped sample would look like a spike
    assign prod = $signed(diff_r) * $signed({1'b0, gain_word});
    assign scaled = prod >>> `GAIN_FRAC_BITS;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= {W{1'b0}};
        end else begin
            out_valid <= diff_v_r;
            if (diff_v_r) begin
                if (scaled > $signed({{(W+2){1'b0}}, 1'b0, {(W-1){1'b1}}})) begin
                    out_data <= {1'b0, {(W-1){1'b1}}};
                end else if (scaled < -$signed({{(W+2){1'b0}}, 1'b1, {(W-1){1'b0}}})) begin
                    out_data <= {1'b1, {(W-1){1'b0}}};
                end else begin
                    out_data <= scaled[W-1:0];
                end
            end
        end
    end
endmodule

//--- hw/channel0_cal_config_regs.v
`include "ch0_cal_map.vh"

module channel0_cal_config_regs #(
    parameter W = 24
) (
    input wire mclk,
    input wire rst,
    input wire [6:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire global_dc_filter_setting,
    input wire sample_valid,
    input wire [W-1:0] sample_data,
    output wire ch0_dc_filter_enable,
    output wire [1:0] ch0_input_select,
    output wire ch0_route_own_pair,
    output wire ch0_inputs_shorted,
    output wire ch0_test_positive,
    output wire ch0_test_negative,
    output wire [W-1:0] ch0_offset_word,
    output wire [W-1:0] ch0_gain_word,
    output wire corrected_valid,
    output wire [W-1:0] corrected_data
);
    // --------------------------------------------------------
    // Register storage
    // --------------------------------------------------------
    reg [1:0] ch0_input_select_r;
    reg ch0_dc_filter_bypass_r;
    reg [15:0] ch0_offset_upper_bits_r;
    reg [7:0] ch0_offset_lower_bits_r;
    reg [15:0] ch0_gain_upper_bits_r;
    reg [7:0] ch0_gain_lower_bits_r;
    reg [3:0] sel_onehot_r;
    reg ack_r;
    reg [15:0] sample_count_r;
    wire [4:0] idx;
    wire req;
    wire wr_go;
    wire rd_go;
    wire wr_cfg;
    wire wr_ofs_hi;
    wire wr_ofs_lo;
    wire wr_gain_hi;
    wire wr_gain_lo;
    reg [31:0] rd_word;

    // --------------------------------------------------------
    // Avalon slave: one wait state, answer at second edge
    // --------------------------------------------------------
    assign idx = avs_address[6:2];
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    assign wr_go = avs_write & ack_r;
    assign rd_go = avs_read & ~ack_r;
    assign wr_cfg = wr_go & (idx == `IDX_CH0_CHANNEL_CONFIG) & avs_byteenable[0];
    assign wr_ofs_hi = wr_go & (idx == `IDX_CH0_OFFSET_CAL_HIGH);
    assign wr_ofs_lo = wr_go & (idx == `IDX_CH0_OFFSET_CAL_LOW) & avs_byteenable[1];
    assign wr_gain_hi = wr_go & (idx == `IDX_CH0_GAIN_CAL_HIGH);
    assign wr_gain_lo = wr_go & (idx == `IDX_CH0_GAIN_CAL_LOW) & avs_byteenable[1];

    function [15:0] merge16;
        input [15:0] old;
        input [15:0] wd;
        input [1:0] be;
        begin
            merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    function [3:0] sel_onehot;
        input [1:0] sel;
        begin
            case (sel)
                `SEL_OWN_PAIR: sel_onehot = 4'h1;
                `SEL_SHORTED: sel_onehot = 4'h2;
                `SEL_TEST_POS: sel_onehot = 4'h4;
                default: sel_onehot = 4'h8;
            endcase
        end
    endfunction

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // --------------------------------------------------------
    // Register writes, taken at the edge waitrequest is low
    // --------------------------------------------------------
    // Decode kept in flops so the select lines never glitch
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ch0_input_select_r <= `RST_CH0_INPUT_SELECT;
            sel_onehot_r <= `RST_CH0_SEL_ONEHOT;
            ch0_dc_filter_bypass_r <= `RST_CH0_DC_BYPASS;
        end else if (wr_cfg) begin
            ch0_input_select_r <= avs_writedata[`CFG_SEL_HI:`CFG_SEL_LO];
            sel_onehot_r <= sel_onehot(avs_writedata[`CFG_SEL_HI:`CFG_SEL_LO]);
            ch0_dc_filter_bypass_r <= avs_writedata[`CFG_BYPASS_BIT];
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ch0_offset_upper_bits_r <= `RST_CH0_OFFSET_CAL_HIGH;
        end else if (wr_ofs_hi) begin
            ch0_offset_upper_bits_r <= merge16(ch0_offset_upper_bits_r,
                avs_writedata[15:0], avs_byteenable[1:0]);
        end
    end

    // Lane 0 of the lower registers is reserved; nothing stores it
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ch0_offset_lower_bits_r <= `RST_CH0_OFFSET_CAL_LOW;
        end else if (wr_ofs_lo) begin
            ch0_offset_lower_bits_r <= avs_writedata[15:8];
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ch0_gain_upper_bits_r <= `RST_CH0_GAIN_CAL_HIGH;
        end else if (wr_gain_hi) begin
            ch0_gain_upper_bits_r <= merge16(ch0_gain_upper_bits_r,
                avs_writedata[15:0], avs_byteenable[1:0]);
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ch0_gain_lower_bits_r <= `RST_CH0_GAIN_CAL_LOW;
        end else if (wr_gain_lo) begin
            ch0_gain_lower_bits_r <= avs_writedata[15:8];
        end
    end

    // --------------------------------------------------------
    // Read path
    // --------------------------------------------------------
    // Unmapped words read zero; writes there are dropped
    always @* begin
        case (idx)
            `IDX_CH0_CHANNEL_CONFIG:
                rd_word = {29'h0, ch0_dc_filter_bypass_r, ch0_input_select_r};
            `IDX_CH0_OFFSET_CAL_HIGH:
                rd_word = {16'h0000, ch0_offset_upper_bits_r};
            `IDX_CH0_OFFSET_CAL_LOW:
                rd_word = {16'h0000, ch0_offset_lower_bits_r, 8'h00};
            `IDX_CH0_GAIN_CAL_HIGH:
                rd_word = {16'h0000, ch0_gain_upper_bits_r};
            `IDX_CH0_GAIN_CAL_LOW:
                rd_word = {16'h0000, ch0_gain_lower_bits_r, 8'h00};
            `IDX_CORR_STATUS:
                rd_word = {16'h0000, sample_count_r};
            default:
                rd_word = 32'h00000000;
        endcase
    end

    // Loaded in the wait state, so it stands at the completing edge
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (rd_go) begin
            avs_readdata <= rd_word;
        end
    end

    // --------------------------------------------------------
    // Channel controls
    // --------------------------------------------------------
    assign ch0_dc_filter_enable = global_dc_filter_setting & ~ch0_dc_filter_bypass_r;
    assign ch0_input_select = ch0_input_select_r;
    assign ch0_route_own_pair = sel_onehot_r[0];
    assign ch0_inputs_shorted = sel_onehot_r[1];
    assign ch0_test_positive = sel_onehot_r[2];
    assign ch0_test_negative = sel_onehot_r[3];
    assign ch0_offset_word = {ch0_offset_upper_bits_r, ch0_offset_lower_bits_r};
    assign ch0_gain_word = {ch0_gain_upper_bits_r, ch0_gain_lower_bits_r};

    // --------------------------------------------------------
    // Correction path and sample counter
    // --------------------------------------------------------
    // Counter wraps; software only watches it advance
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sample_count_r <= 16'h0000;
        end else if (corrected_valid) begin
            sample_count_r <= sample_count_r + 16'h0001;
        end
    end

    cal_correct #(
        .W(W)
    ) u_correct (
        .mclk(mclk),
        .rst(rst),
        .in_valid(sample_valid),
        .in_data(sample_data),
        .offset_word(ch0_offset_word),
        .gain_word(ch0_gain_word),
        .out_valid(corrected_valid),
        .out_data(corrected_data)
    );
endmodule

//--- sim/cal_regs_chk.sv
`include "ch0_cal_map.vh"
// ----------
// Register and decode checks
// ----------
module cal_regs_chk #(
    parameter W = 24
) (
    input wire mclk,
    input wire rst,
    input wire [6:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire global_dc_filter_setting,
    input wire sample_valid,
    input wire ch0_dc_filter_enable,
    input wire [1:0] ch0_input_select,
    input wire ch0_route_own_pair,
    input wire ch0_inputs_shorted,
    input wire ch0_test_positive,
    input wire ch0_test_negative,
    input wire [W-1:0] ch0_offset_word,
    input wire [W-1:0] ch0_gain_word,
    input wire corrected_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [4:0] idx = avs_address[6:2];
    wire wdone = avs_write && !avs_waitrequest && avs_byteenable[1:0] == 2'h3;
    wire rdone = avs_read && !avs_waitrequest;
    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_wr(i);
        wdone && idx == i;
    endsequence
    a_one_wait: assert property (s_req |=> !avs_waitrequest)
        else $error("wait state not single");
    a_bypass_filter: assert property (
        s_wr(`IDX_CH0_CHANNEL_CONFIG) |=>
        ch0_dc_filter_enable == (global_dc_filter_setting && !$past(avs_writedata[2])))
        else $error("filter enable wrong");
    a_select_store: assert property (
        s_wr(`IDX_CH0_CHANNEL_CONFIG) |=> ch0_input_select == $past(avs_writedata[1:0]))
        else $error("input select not stored");
    a_select_decode: assert property ({ch0_test_negative, ch0_test_positive,
        ch0_inputs_shorted, ch0_route_own_pair} == 4'h1 << ch0_input_select)
        else $error("input decode wrong");
    a_offset_high: assert property (
        s_wr(`IDX_CH0_OFFSET_CAL_HIGH) |=> ch0_offset_word[23:8] == $past(avs_writedata[15:0]))
        else $error("offset high wrong");
    a_offset_low: assert property (
        s_wr(`IDX_CH0_OFFSET_CAL_LOW) |=> ch0_offset_word[7:0] == $past(avs_writedata[15:8]))
        else $error("offset low wrong");
    a_gain_high: assert property (
        s_wr(`IDX_CH0_GAIN_CAL_HIGH) |=> ch0_gain_word[23:8] == $past(avs_writedata[15:0]))
        else $error("gain high wrong");
    a_gain_low: assert property (
        s_wr(`IDX_CH0_GAIN_CAL_LOW) |=> ch0_gain_word[7:0] == $past(avs_writedata[15:8]))
        else $error("gain low wrong");
    a_reserved_zero: assert property (rdone && (idx == `IDX_CH0_OFFSET_CAL_LOW ||
        idx == `IDX_CH0_GAIN_CAL_LOW) |-> avs_readdata[7:0] == 8'h00)
        else $error("reserved byte not zero");
    a_corr_pulse: assert property (sample_valid |-> ##[2:3] corrected_valid)
        else $error("corrected result missing");
endmodule
bind channel0_cal_config_regs cal_regs_chk #(.W(W)) u_chk (.mclk, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .global_dc_filter_setting, .sample_valid, .ch0_dc_filter_enable, .ch0_input_select,
    .ch0_route_own_pair, .ch0_inputs_shorted, .ch0_test_positive, .ch0_test_negative,
    .ch0_offset_word, .ch0_gain_word, .corrected_valid);

//--- sim/testbench.sv
`include "ch0_cal_map.vh"
// ----------
// Register bank bench
// ----------
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, rst = 1'b1, rd_r = 1'b0, wr_r = 1'b0, glob = 1'b1, sv = 1'b0;
    logic [6:0] adr = 7'h00;
    logic [3:0] be = 4'hF;
    logic [31:0] wd = 32'h0, q;
    logic [23:0] sd = 24'h0;
    wire [31:0] rdata;
    wire wait_r, en, own, sh, pos, neg, cv;
    wire [1:0] sel;
    wire [23:0] ow, gw, cd;
    int mismatches = 0, comparisons = 0, k;
    channel0_cal_config_regs dut (.mclk, .rst, .avs_address(adr), .avs_read(rd_r),
        .avs_write(wr_r), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(wait_r), .global_dc_filter_setting(glob), .sample_valid(sv),
        .sample_data(sd), .ch0_dc_filter_enable(en), .ch0_input_select(sel),
        .ch0_route_own_pair(own), .ch0_inputs_shorted(sh), .ch0_test_positive(pos),
        .ch0_test_negative(neg), .ch0_offset_word(ow), .ch0_gain_word(gw),
        .corrected_valid(cv), .corrected_data(cd));
    task automatic end_of_test;
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Request stays up between calls so back-to-back cycles are exercised
    task automatic acc(input logic w, input logic [4:0] i, input logic [15:0] d);
        int n;
        n = 0;
        adr <= {i, 2'h0};
        rd_r <= !w;
        wr_r <= w;
        wd <= {16'h0000, d};
        do begin
            @(posedge mclk);
            n++;
        end while (wait_r !== 1'b0 && n < 20);
        q = rdata;
        if (n >= 20) chk(32'h0, 32'hFFFFFFFF);
    endtask
    task automatic rd(input logic [4:0] i, input logic [31:0] exp);
        acc(1'b0, i, 16'h0000);
        chk(q, exp);
    endtask
    task automatic idle;
        rd_r <= 1'b0;
        wr_r <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic smp(input logic [23:0] d, input logic [23:0] exp);
        int n;
        n = 0;
        sd <= d;
        sv <= 1'b1;
        @(posedge mclk);
        sv <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (cv !== 1'b1 && n < 8);
        chk({cv, cd}, {1'b1, exp});
    endtask
    initial forever #2.5 mclk = ~mclk;
    initial begin
        #20000;
        mismatches++;
        end_of_test;
    end
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk({en, own, gw}, {2'h3, 24'h800000});
        rd(`IDX_CH0_CHANNEL_CONFIG, 32'h0);
        rd(`IDX_CH0_OFFSET_CAL_HIGH, 32'h0);
        rd(`IDX_CH0_OFFSET_CAL_LOW, 32'h0);
        rd(`IDX_CH0_GAIN_CAL_HIGH, 32'h8000);
        rd(`IDX_CH0_GAIN_CAL_LOW, 32'h0);
        rd(5'h1E, 32'h0);
        for (k = 0; k < 8; k++) begin
            glob <= k[2];
            acc(1'b1, `IDX_CH0_CHANNEL_CONFIG, {13'h0, k[0], k[1:0]});
            rd(`IDX_CH0_CHANNEL_CONFIG, {29'h0, k[0], k[1:0]});
            idle;
            chk({en, neg, pos, sh, own, sel}, {k[2] & ~k[0], 4'h1 << k[1:0], k[1:0]});
        end
        acc(1'b1, `IDX_CH0_OFFSET_CAL_HIGH, 16'h1234);
        acc(1'b1, `IDX_CH0_OFFSET_CAL_LOW, 16'hABCD);
        acc(1'b1, `IDX_CH0_GAIN_CAL_HIGH, 16'hFFFF);
        acc(1'b1, `IDX_CH0_GAIN_CAL_LOW, 16'h5A77);
        rd(`IDX_CH0_OFFSET_CAL_LOW, 32'hAB00);
        rd(`IDX_CH0_GAIN_CAL_LOW, 32'h5A00);
        rd(`IDX_CH0_OFFSET_CAL_HIGH, 32'h1234);
        rd(`IDX_CH0_GAIN_CAL_HIGH, 32'hFFFF);
        idle;
        chk({ow, gw[23:16]}, 32'h1234ABFF);
        chk(gw, 24'hFFFF5A);
        be <= 4'h1;
        acc(1'b1, `IDX_CH0_OFFSET_CAL_HIGH, 16'h5566);
        acc(1'b1, `IDX_CH0_OFFSET_CAL_LOW, 16'h7700);
        be <= 4'h2;
        acc(1'b1, `IDX_CH0_CHANNEL_CONFIG, 16'h0000);
        be <= 4'hF;
        rd(`IDX_CH0_OFFSET_CAL_HIGH, 32'h1266);
        rd(`IDX_CH0_OFFSET_CAL_LOW, 32'hAB00);
        rd(`IDX_CH0_CHANNEL_CONFIG, 32'h7);
        acc(1'b1, `IDX_CH0_OFFSET_CAL_HIGH, 16'h0000);
        acc(1'b1, `IDX_CH0_OFFSET_CAL_LOW, 16'h1000);
        acc(1'b1, `IDX_CH0_GAIN_CAL_HIGH, 16'h8000);
        acc(1'b1, `IDX_CH0_GAIN_CAL_LOW, 16'h0000);
        idle;
        smp(24'h000110, 24'h000100);
        acc(1'b1, `IDX_CH0_GAIN_CAL_HIGH, 16'h4000);
        idle;
        smp(24'h000110, 24'h000080);
        // Offset taken before scaling, so zero input gives minus half the offset
        smp(24'h000000, 24'hFFFFF8);
        // Gain near two drives both ends into saturation
        acc(1'b1, `IDX_CH0_GAIN_CAL_HIGH, 16'hFFFF);
        idle;
        smp(24'h7FFFF0, 24'h7FFFFF);
        smp(24'h800000, 24'h800000);
        rd(`IDX_CORR_STATUS, 32'h5);
        idle;
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk({en, own, gw}, {2'h3, 24'h800000});
        rd(`IDX_CH0_CHANNEL_CONFIG, 32'h0);
        rd(`IDX_CH0_OFFSET_CAL_LOW, 32'h0);
        rd(`IDX_CH0_GAIN_CAL_HIGH, 32'h8000);
        rd(`IDX_CORR_STATUS, 32'h0);
        idle;
        end_of_test;
    end
endmodule
